// [inc/tsp_pkg.sv]
// Constants, types and helpers for the thermometer serial/PWM port
// Summary of operation
// - Zero word write erases an EEPROM cell
// - Clock low 1.44 ms selects serial mode
// - Clock low over 21 ms resets engine
// - Clock high over 52 us resets engine
// - Acknowledge driven within 2.5 us
// - Own acknowledge released within 1.5 us
// - Line freed within 0.5 us for host ack
// - Line reclaimed within 1.5 us after host ack
// - Data changes 300 ns after clock fall
// - Decode EEPROM, RAM and sleep command bytes
// - Temperature word top bit flags error
// - Sleep accepted only in serial mode
// - Clock low 50 ms wakes into serial mode
// - Configured PWM drives data pin after reset
// - Request ignores data; PWM stays off
// - PWM disabled means serial from reset
// - PWM period 10 Hz or 1 kHz
// - Start band, 10-bit band, duty under 0.625
// - Code is scaled temperature above stored minimum
package tsp_pkg;
  localparam int unsigned CLK_NS       = 5;
  localparam int unsigned T_REQ_NS     = 1440000;
  localparam int unsigned T_LOW_NS     = 21000000;
  localparam int unsigned T_HIGH_NS    = 52000;
  localparam int unsigned T_HOLD_NS    = 300;
  localparam int unsigned T_WAKE_NS    = 50000000;
  localparam int unsigned T_PSLOW_NS   = 100000000;
  localparam int unsigned T_PFAST_NS   = 1000000;
  localparam int unsigned REQ_CYC      = (T_REQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LOW_CYC      = T_LOW_NS / CLK_NS;
  localparam int unsigned HIGH_CYC     = T_HIGH_NS / CLK_NS;
  localparam int unsigned HOLD_CYC     = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WAKE_CYC     = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PSLOW_CYC    = T_PSLOW_NS / CLK_NS;
  localparam int unsigned PFAST_CYC    = T_PFAST_NS / CLK_NS;
  localparam int          CNT_W        = 25;
  localparam logic [7:0]  OFS_CFG      = 8'h00;
  localparam logic [7:0]  OFS_STAT     = 8'h04;
  localparam logic [7:0]  OFS_TA       = 8'h08;
  localparam logic [7:0]  OFS_TO       = 8'h0c;
  localparam logic [1:0]  EE_WIN       = 2'h1;
  localparam int          CFG_PWM_EN   = 0;
  localparam int          CFG_FAST     = 1;
  localparam int          CFG_SRC_OBJ  = 2;
  localparam logic [2:0]  CFG_RST      = 3'h2;
  localparam logic [15:0] EE0_RST      = 16'h005b;
  localparam logic [3:0]  CMD_EE       = 4'h1;
  localparam logic [3:0]  CMD_RAM      = 4'h2;
  localparam logic [7:0]  CMD_SLEEP    = 8'hc6;
  localparam logic [3:0]  RAM_TA       = 4'h6;
  localparam logic [3:0]  RAM_TO       = 4'h7;
  localparam logic [3:0]  EE_TMIN      = 4'h0;
  localparam logic [3:0]  EE_TRNG      = 4'h1;
  localparam logic [7:0]  CRC_POLY     = 8'h07;
  localparam logic [24:0] PWM_SCALE    = 25'h00003ff;
  localparam logic [9:0]  PWM_MAX      = 10'h3ff;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RXB  = 6'b000010,
    ST_ACK  = 6'b000100,
    ST_TXB  = 6'b001000,
    ST_MACK = 6'b010000,
    ST_SKIP = 6'b100000
  } tsp_state_t;

  function automatic logic [7:0] tsp_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

// [design/tsp_smbus_pwm.sv]
// Thermometer serial target port with PWM output and APB register slave
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tsp_smbus_pwm #(
  parameter int unsigned P_REQ   = tsp_pkg::REQ_CYC,
  parameter int unsigned P_LOW   = tsp_pkg::LOW_CYC,
  parameter int unsigned P_HIGH  = tsp_pkg::HIGH_CYC,
  parameter int unsigned P_WAKE  = tsp_pkg::WAKE_CYC,
  parameter int unsigned P_PSLOW = tsp_pkg::PSLOW_CYC,
  parameter int unsigned P_PFAST = tsp_pkg::PFAST_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output var  logic        o_sda_o,
  output var  logic        o_sda_oe
);
  import tsp_pkg::*;
  localparam logic [CNT_W-1:0] REQ_C  = CNT_W'(P_REQ);
  localparam logic [CNT_W-1:0] LOW_C  = CNT_W'(P_LOW);
  localparam logic [CNT_W-1:0] HIGH_C = CNT_W'(P_HIGH);
  localparam logic [CNT_W-1:0] WAKE_C = CNT_W'(P_WAKE);
  localparam logic [CNT_W-1:0] SLOW_C = CNT_W'(P_PSLOW);
  localparam logic [CNT_W-1:0] FAST_C = CNT_W'(P_PFAST);
  localparam logic [6:0]       HOLD_C = 7'(HOLD_CYC);

  logic             scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic             scl_rise, scl_fall, start_c, stop_c;
  logic [2:0]       cfg_r, cfg_nxt;
  logic [15:0]      ta_r, ta_nxt, to_r, to_nxt;
  logic [15:0]      ee_mem [16];
  logic             rd_hit;
  logic [31:0]      rd_val;
  logic             apb_acc, apb_wr, ee_hit;
  tsp_state_t       st_r, st_nxt;
  logic [3:0]       bit_r, bit_nxt;
  logic [2:0]       byte_r, byte_nxt;
  logic [1:0]       txn_r, txn_nxt;
  logic [7:0]       sh_r, sh_nxt, txsh_r, txsh_nxt, crc_r, crc_nxt, cmd_r, cmd_nxt;
  logic [15:0]      word_r, word_nxt, ram_q;
  logic             drive_r, drive_nxt, rep_r, rep_nxt, mack_r, mack_nxt;
  logic             pec_r, pec_nxt, asleep_r, asleep_nxt, req_r, req_nxt;
  logic [CNT_W-1:0] lowc_r, lowc_nxt, highc_r, highc_nxt;
  logic [6:0]       holdc_r, holdc_nxt;
  logic             fire_c, comm_rst, smb_on, pwm_mode, oe_nxt;
  logic             ee_we;
  logic [3:0]       ee_wa;
  logic [15:0]      ee_wd;
  logic [7:0]       txb;
  logic [CNT_W-1:0] pcnt_r, pcnt_nxt, thr_r, thr_nxt, period;
  logic [9:0]       code_r, code_nxt;
  logic [15:0]      tsel, diff;
  logic [24:0]      quot;
  logic [34:0]      band;
  logic             pwm_hi;

  // Two-stage synchronisers; edges are taken only from the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;
  assign smb_on   = ~cfg_r[CFG_PWM_EN] | req_r;
  assign pwm_mode = ~smb_on & ~asleep_r;

  // APB slave: zero-wait, answer in the first access cycle
  assign apb_acc = i_psel & i_penable & o_pready;
  assign apb_wr  = apb_acc & i_pwrite;
  assign ee_hit  = (i_paddr[7:6] == EE_WIN);

  always_comb begin
    rd_hit = (i_paddr[1:0] == 2'h0);
    rd_val = 32'h0;
    if (ee_hit) begin
      rd_val = {16'h0, ee_mem[i_paddr[5:2]]};
    end else begin
      case (i_paddr)
        OFS_CFG:  rd_val = {29'h0, cfg_r};
        OFS_STAT: rd_val = {28'h0, pwm_mode, st_r != ST_IDLE, asleep_r, smb_on};
        OFS_TA:   rd_val = {16'h0, ta_r};
        OFS_TO:   rd_val = {16'h0, to_r};
        default:  rd_hit = 1'b0;
      endcase
    end
    cfg_nxt = cfg_r;
    ta_nxt  = ta_r;
    to_nxt  = to_r;
    if (apb_wr && rd_hit && !ee_hit) begin
      case (i_paddr)
        OFS_CFG: cfg_nxt = i_pwdata[2:0];
        OFS_TA:  ta_nxt = i_pwdata[15:0];
        OFS_TO:  to_nxt = i_pwdata[15:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      cfg_r     <= CFG_RST;
      ta_r      <= 16'h0;
      to_r      <= 16'h0;
    end else begin
      o_prdata  <= rd_val;
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~rd_hit;
      cfg_r     <= cfg_nxt;
      ta_r      <= ta_nxt;
      to_r      <= to_nxt;
    end
  end

  // EEPROM cells: serial writes only set bits, so a cell must be cleared first; APB writes replace the cell unless a serial write lands in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 16; i++) begin
        ee_mem[i] <= (i == 0) ? EE0_RST : 16'h0;
      end
    end else if (ee_we) begin
      ee_mem[ee_wa] <= (ee_wd == 16'h0) ? 16'h0 : (ee_mem[ee_wa] | ee_wd);
    end else if (apb_wr && ee_hit && rd_hit) begin
      ee_mem[i_paddr[5:2]] <= i_pwdata[15:0];
    end
  end

  // RAM view; software keeps the error flag in the top bit
  always_comb begin
    case (sh_r[3:0])
      RAM_TA:  ram_q = ta_r;
      RAM_TO:  ram_q = to_r;
      default: ram_q = 16'h0;
    endcase
    case (txn_r)
      2'd0:    txb = word_r[7:0];
      2'd1:    txb = word_r[15:8];
      default: txb = crc_r;
    endcase
  end

  // Serial target engine
  always_comb begin
    st_nxt    = st_r;
    bit_nxt   = bit_r;
    byte_nxt  = byte_r;
    txn_nxt   = txn_r;
    sh_nxt    = sh_r;
    txsh_nxt  = txsh_r;
    crc_nxt   = crc_r;
    cmd_nxt   = cmd_r;
    word_nxt  = word_r;
    drive_nxt = drive_r;
    rep_nxt   = rep_r;
    mack_nxt  = mack_r;
    pec_nxt   = pec_r;
    asleep_nxt = asleep_r;
    req_nxt   = req_r;
    comm_rst  = 1'b0;
    ee_we     = 1'b0;
    ee_wa     = cmd_r[3:0];
    ee_wd     = word_r;
    lowc_nxt  = scl_s ? '0 : ((lowc_r == WAKE_C) ? lowc_r : lowc_r + 1'b1);
    highc_nxt = (scl_s && st_r != ST_IDLE && highc_r != HIGH_C) ? highc_r + 1'b1 : '0;
    holdc_nxt = scl_fall ? HOLD_C : ((holdc_r != 7'h0) ? holdc_r - 1'b1 : holdc_r);
    fire_c    = (holdc_r == 7'h1);
    if (asleep_r) begin
      if (lowc_r == WAKE_C) begin
        asleep_nxt = 1'b0;
        req_nxt    = 1'b1;
        comm_rst   = 1'b1;
      end
    end else if (!smb_on) begin
      // Data pin carries PWM here and is never looked at
      if (lowc_r == REQ_C) begin
        req_nxt  = 1'b1;
        // Else a PWM low phase would keep the line pulled after the switch
        comm_rst = 1'b1;
      end
    end else if (lowc_r == LOW_C || highc_r == HIGH_C) begin
      comm_rst = 1'b1;
    end else if (start_c) begin
      rep_nxt  = (st_r != ST_IDLE);
      crc_nxt  = (st_r != ST_IDLE) ? crc_r : 8'h0;
      st_nxt   = ST_RXB;
      bit_nxt  = 4'h0;
      byte_nxt = 3'h0;
    end else if (stop_c) begin
      if (!rep_r && pec_r && byte_r == 3'd5 && cmd_r[7:4] == CMD_EE) begin
        ee_we = 1'b1;
      end
      if (!rep_r && pec_r && byte_r == 3'd3 && cmd_r == CMD_SLEEP) begin
        asleep_nxt = smb_on;
      end
      st_nxt    = ST_IDLE;
      drive_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_RXB: begin
          if (scl_rise) begin
            sh_nxt  = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            st_nxt    = ST_ACK;
            drive_nxt = 1'b1;
            crc_nxt   = tsp_crc8(crc_r, sh_r);
            byte_nxt  = byte_r + 3'h1;
            case (byte_r)
              3'd0: begin
                if ((sh_r[7:1] != ee_mem[EE_TMIN][6:0] && sh_r[7:1] != 7'h0)
                    || sh_r[0] != rep_r) begin
                  st_nxt    = ST_SKIP;
                  drive_nxt = 1'b0;
                end
              end
              3'd1: begin
                cmd_nxt = sh_r;
                if (sh_r[7:4] == CMD_EE) begin
                  word_nxt = ee_mem[sh_r[3:0]];
                end else if (sh_r[7:4] == CMD_RAM) begin
                  word_nxt = ram_q;
                end else if (sh_r != CMD_SLEEP) begin
                  st_nxt    = ST_SKIP;
                  drive_nxt = 1'b0;
                end
              end
              3'd2: begin
                word_nxt[7:0] = sh_r;
                pec_nxt       = (sh_r == crc_r);
              end
              3'd3: begin
                word_nxt[15:8] = sh_r;
                pec_nxt        = 1'b0;
              end
              default: pec_nxt = (sh_r == crc_r);
            endcase
            // A checksum byte that fails is refused so the host retries
            if ((byte_r == 3'd4 || (byte_r == 3'd2 && cmd_r == CMD_SLEEP)) && sh_r != crc_r) begin
              st_nxt    = ST_SKIP;
              drive_nxt = 1'b0;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_nxt = 4'h0;
            if (rep_r) begin
              st_nxt    = ST_TXB;
              txsh_nxt  = txb;
              drive_nxt = ~txb[7];
              crc_nxt   = tsp_crc8(crc_r, txb);
              txn_nxt   = 2'd1;
            end else begin
              st_nxt    = ST_RXB;
              drive_nxt = 1'b0;
            end
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            if (bit_r == 4'h7) begin
              st_nxt    = ST_MACK;
              drive_nxt = 1'b0;
            end else begin
              bit_nxt   = bit_r + 4'h1;
              txsh_nxt  = {txsh_r[6:0], 1'b0};
              drive_nxt = ~txsh_r[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_nxt = ~sda_s;
          end else if (scl_fall) begin
            bit_nxt = 4'h0;
            if (mack_r && txn_r != 2'd3) begin
              st_nxt    = ST_TXB;
              txsh_nxt  = txb;
              drive_nxt = ~txb[7];
              crc_nxt   = tsp_crc8(crc_r, txb);
              txn_nxt   = txn_r + 2'd1;
            end else begin
              st_nxt = ST_SKIP;
            end
          end
        end
        ST_SKIP: drive_nxt = 1'b0;
        default: st_nxt = ST_IDLE;
      endcase
    end
    if (comm_rst) begin
      st_nxt    = ST_IDLE;
      drive_nxt = 1'b0;
      rep_nxt   = 1'b0;
      txn_nxt   = 2'd0;
    end
    if (st_nxt == ST_IDLE) begin
      txn_nxt = 2'd0;
    end
    // In serial mode the pin moves on the hold strobe, a stop or an engine reset, never straight off the clock edge
    if (comm_rst) begin
      oe_nxt = 1'b0;
    end else if (pwm_mode) begin
      oe_nxt = ~pwm_hi;
    end else if (asleep_r || stop_c) begin
      oe_nxt = 1'b0;
    end else if (fire_c) begin
      oe_nxt = drive_r;
    end else begin
      oe_nxt = o_sda_oe;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r     <= ST_IDLE;
      bit_r    <= 4'h0;
      byte_r   <= 3'h0;
      txn_r    <= 2'h0;
      sh_r     <= 8'h0;
      txsh_r   <= 8'h0;
      crc_r    <= 8'h0;
      cmd_r    <= 8'h0;
      word_r   <= 16'h0;
      drive_r  <= 1'b0;
      rep_r    <= 1'b0;
      mack_r   <= 1'b0;
      pec_r    <= 1'b0;
      asleep_r <= 1'b0;
      req_r    <= 1'b0;
      lowc_r   <= '0;
      highc_r  <= '0;
      holdc_r  <= 7'h0;
      o_sda_oe <= 1'b0;
      o_sda_o  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      bit_r    <= bit_nxt;
      byte_r   <= byte_nxt;
      txn_r    <= txn_nxt;
      sh_r     <= sh_nxt;
      txsh_r   <= txsh_nxt;
      crc_r    <= crc_nxt;
      cmd_r    <= cmd_nxt;
      word_r   <= word_nxt;
      drive_r  <= drive_nxt;
      rep_r    <= rep_nxt;
      mack_r   <= mack_nxt;
      pec_r    <= pec_nxt;
      asleep_r <= asleep_nxt;
      req_r    <= req_nxt;
      lowc_r   <= lowc_nxt;
      highc_r  <= highc_nxt;
      holdc_r  <= holdc_nxt;
      o_sda_oe <= oe_nxt;
      o_sda_o  <= 1'b0;
    end
  end

  // PWM: code refreshed every cycle, band latched at each period start
  always_comb begin
    period   = cfg_r[CFG_FAST] ? FAST_C : SLOW_C;
    tsel     = cfg_r[CFG_SRC_OBJ] ? to_r : ta_r;
    diff     = {1'b0, tsel[14:0]} - {1'b0, ee_mem[EE_TMIN][14:0]};
    quot     = (25'(diff[14:0]) * PWM_SCALE) / {9'h0, ee_mem[EE_TRNG]};
    code_nxt = (diff[15] || ee_mem[EE_TRNG] == 16'h0) ? 10'h0
             : ((quot > 25'(PWM_MAX)) ? PWM_MAX : quot[9:0]);
    band     = 35'(code_r) * 35'(period >> 1);
    pcnt_nxt = (pcnt_r >= period - 1'b1) ? '0 : pcnt_r + 1'b1;
    thr_nxt  = (pcnt_r >= period - 1'b1) ? (period >> 3) + band[34:10] : thr_r;
    pwm_hi   = (pcnt_r < thr_r);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pcnt_r <= '0;
      thr_r  <= '0;
      code_r <= 10'h0;
    end else begin
      pcnt_r <= pcnt_nxt;
      thr_r  <= thr_nxt;
      code_r <= code_nxt;
    end
  end

  default clocking dc @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  ack_drive_a: assert property (
    (st_r == ST_RXB && st_nxt == ST_ACK && !stop_c) |-> ##[60:500] o_sda_oe)
    else $error("ack not driven in time");
  ack_free_a: assert property (
    (st_r == ST_ACK && st_nxt == ST_RXB) |-> ##[60:300] !o_sda_oe)
    else $error("own ack not released in time");
  host_free_a: assert property (
    (st_r == ST_TXB && st_nxt == ST_MACK) |-> ##[60:100] !o_sda_oe)
    else $error("line not freed for host ack");
  reclaim_a: assert property (
    (st_r == ST_MACK && st_nxt == ST_TXB) |-> ##[60:300] (o_sda_oe == drive_r))
    else $error("line not reclaimed after host ack");
  hold_gap_a: assert property (
    ($changed(o_sda_oe) && $past(smb_on) && !$past(asleep_r))
      |-> ($past(fire_c) || $past(comm_rst) || $past(stop_c)))
    else $error("data changed off the hold strobe");
  req_mode_a: assert property (
    ($rose(req_r) && !$past(asleep_r)) |-> ($past(lowc_r) == REQ_C))
    else $error("mode request at wrong low time");
  low_tout_a: assert property (
    (lowc_r == LOW_C && smb_on && !asleep_r) |=> (st_r == ST_IDLE && !o_sda_oe))
    else $error("low timeout did not reset");
  high_tout_a: assert property (
    (highc_r == HIGH_C && smb_on && !asleep_r) |=> (st_r == ST_IDLE))
    else $error("high timeout did not reset");
  sleep_smb_a: assert property (
    $rose(asleep_r) |-> $past(smb_on))
    else $error("sleep entered outside serial mode");
  wake_mode_a: assert property (
    $fell(asleep_r) |-> (req_r && st_r == ST_IDLE && $past(lowc_r) == WAKE_C))
    else $error("wake not into serial mode");
  pwm_keep_a: assert property (
    req_r |=> req_r)
    else $error("PWM re-enabled without reset");
  duty_cap_a: assert property (
    (pwm_mode && pcnt_r == '0 && $stable(cfg_r))
      |-> (thr_r >= (period >> 3) && thr_r <= (period >> 3) + (period >> 1)))
    else $error("pwm band out of range");
  erase_a: assert property (
    (ee_we && ee_wd == 16'h0) |=> (ee_mem[$past(ee_wa)] == 16'h0))
    else $error("zero write did not erase");

  read_c: cover property (st_r == ST_MACK && st_nxt == ST_SKIP && txn_r == 2'd3);
  write_c: cover property (ee_we);
  sleep_c: cover property ($rose(asleep_r));
  request_c: cover property ($rose(req_r) && !$past(asleep_r));
endmodule // tsp_smbus_pwm
`default_nettype wire

// [test/tsp_host_model.sv]
// Behavioural SMBus host driving the clock pin and pulling the data pin
`timescale 1ns/1ps
`default_nettype none
module tsp_host_model (
  input  wire logic i_clk,
  input  wire logic i_wire,
  output var  logic o_scl,
  output var  logic o_pull
);
  // Rate scaled down with the shortened timeouts to keep the run short
  localparam int HALF  = 100;
  localparam int SETUP = 80;
  initial begin
    o_scl = 1'b1;  // Idles high, so also through sleep and PWM use
    o_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Serves as start and as repeated start
  task automatic start_c();
    o_pull <= 1'b0;
    wt(HALF);
    o_scl <= 1'b1;
    wt(HALF);
    o_pull <= 1'b1;
    wt(HALF);
    o_scl <= 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r, output logic early);
    wt(SETUP);
    early = i_wire;
    o_pull <= !b;  // Changed 400 ns after the fall, read 250 ns after the rise
    wt(HALF - SETUP);
    o_scl <= 1'b1;
    wt(HALF / 2);
    r = i_wire;
    wt(HALF / 2);
    o_scl <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic x;
    logic e;
    for (int i = 7; i >= 0; i--) bit_io(d[i], x, e);
    bit_io(1'b1, x, e);
    ack = !x;
  endtask
  task automatic get_byte(input logic hack, output logic [7:0] d, output logic early);
    logic x;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i], x);
    bit_io(!hack, x, early);
  endtask
  task automatic stop_c();
    wt(SETUP);
    o_pull <= 1'b1;
    wt(HALF - SETUP);
    o_scl <= 1'b1;
    wt(HALF);
    o_pull <= 1'b0;
    wt(HALF);
  endtask
  // Long low for request or wake; data level may be anything
  task automatic low_for(input int n, input logic p);
    o_scl <= 1'b0;
    o_pull <= p;
    wt(n);
    o_scl <= 1'b1;
    o_pull <= 1'b0;
    wt(HALF);
  endtask
endmodule  // tsp_host_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the thermometer serial/PWM port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tsp_pkg::*;
  localparam logic [6:0] ADR = EE0_RST[6:0];
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, sda_o, sda_oe, scl, pull;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          fail_count = 0;
  int          n_tests = 0;
  wire logic   sda_wire = !(sda_oe | pull);  // Pulled up unless someone pulls low
  // Shortened counts; high timeout keeps its default
  tsp_smbus_pwm #(.P_REQ(200), .P_LOW(2000), .P_WAKE(3000), .P_PSLOW(4096),
    .P_PFAST(1024)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_scl(scl), .i_sda(sda_wire), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe));
  tsp_host_model host (.i_clk(clk), .i_wire(sda_wire), .o_scl(scl), .o_pull(pull));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     output logic [31:0] d, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    d = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic er;
    apb(1'b1, a, v, d, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    check(d, e, "read data");
    check(32'(er), 32'(ee), "slave error");
  endtask
  // Sends n bytes and then their PEC; ok only if every byte was acknowledged
  task automatic smb_tx(input int n, input logic [7:0] b [4], output logic ok);
    logic [7:0] c;
    logic a;
    c = 8'h00;
    ok = 1'b1;
    host.start_c();
    for (int i = 0; i <= n; i++) begin
      host.put_byte(i < n ? b[i] : c, a);
      c = (i < n) ? crc(c, b[i]) : c;
      ok = ok & a;
    end
    host.stop_c();
  endtask
  task automatic wait_lvl(input logic v, inout int n);
    while (sda_wire !== v && n < 9000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic t_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(32'(sda_oe), 32'h0, "pin released");
    check(32'(sda_o), 32'h0, "open drain level");
    rd(OFS_CFG, 32'h2, 1'b0);
    rd(OFS_STAT, 32'h1, 1'b0);
    rd(8'h40, 32'(EE0_RST), 1'b0);
    rd(8'h20, 32'h0, 1'b1);
  endtask
  task automatic t_read();
    logic [7:0] lo, hi, pec, c;
    logic a0, a1, a2, e0, e1, e2;
    wr(OFS_TO, 32'h4022);
    host.start_c();
    host.put_byte({ADR, 1'b0}, a0);
    host.put_byte({CMD_RAM, RAM_TO}, a1);
    host.start_c();
    host.put_byte({ADR, 1'b1}, a2);
    host.get_byte(1'b1, lo, e0);
    host.get_byte(1'b1, hi, e1);
    host.get_byte(1'b0, pec, e2);
    host.stop_c();
    c = crc(crc(crc(crc(crc(8'h00, {ADR, 1'b0}), {CMD_RAM, RAM_TO}), {ADR, 1'b1}), 8'h22), 8'h40);
    check(32'({a0, a1, a2}), 32'h7, "acks");
    check(32'({e0, e1}), 32'h3, "freed for host ack");
    check(32'({hi, lo}), 32'h4022, "object word");
    check(32'(pec), 32'(c), "pec");
  endtask
  // Only word three is written; calibration words are left alone
  task automatic t_eeprom();
    logic ok;
    wr(8'h4c, 32'h1234);
    smb_tx(4, '{{ADR, 1'b0}, {CMD_EE, 4'h3}, 8'hf0, 8'h00}, ok);
    check(32'(ok), 32'h1, "write acked");
    rd(8'h4c, 32'h12f4, 1'b0);
    smb_tx(4, '{{ADR, 1'b0}, {CMD_EE, 4'h3}, 8'h00, 8'h00}, ok);
    rd(8'h4c, 32'h0, 1'b0);
    smb_tx(2, '{{ADR, 1'b0}, 8'h35, 8'h00, 8'h00}, ok);
    check(32'(ok), 32'h0, "unknown command");
  endtask
  task automatic t_sleep();
    logic ok;
    smb_tx(2, '{{ADR, 1'b0}, CMD_SLEEP, 8'h00, 8'h00}, ok);
    rd(OFS_STAT, 32'h3, 1'b0);
    host.low_for(3100, 1'b0);
    rd(OFS_STAT, 32'h1, 1'b0);
  endtask
  task automatic t_timeout();
    logic a;
    host.start_c();
    host.put_byte({ADR, 1'b0}, a);
    rd(OFS_STAT, 32'h5, 1'b0);
    host.low_for(100, 1'b0);
    host.wt(10400);
    rd(OFS_STAT, 32'h1, 1'b0);
    host.start_c();
    host.put_byte({ADR, 1'b0}, a);
    host.low_for(2100, 1'b0);
    rd(OFS_STAT, 32'h1, 1'b0);
  endtask
  // Second period is measured; the first may still run at the old length
  task automatic t_pwm(input logic [31:0] cfg, input int per);
    int hi, t, e;
    wr(OFS_CFG, cfg);
    rd(OFS_STAT, 32'h8, 1'b0);
    e = per / 8 + (511 * (per / 2)) / 1024;
    for (int k = 0; k < 2; k++) begin
      t = 0;
      wait_lvl(1'b0, t);
      wait_lvl(1'b1, t);
      hi = 0;
      wait_lvl(1'b0, hi);
      t = 0;
      wait_lvl(1'b1, t);
    end
    check(32'(hi + t), 32'(per), "pwm period");
    check(32'(hi >= e - 1 && hi <= e + 1), 32'h1, "pwm high");
  endtask
  task automatic t_request();
    host.low_for(250, 1'b1);
    check(32'(sda_oe), 32'h0, "pin freed after request");
    rd(OFS_STAT, 32'h1, 1'b0);
    wr(OFS_CFG, 32'h3);
    rd(OFS_STAT, 32'h1, 1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t_reset();
    t_read();
    t_eeprom();
    t_sleep();
    t_timeout();
    // Wake left serial mode latched; only a reset re-arms PWM
    t_reset();
    wr(8'h40, 32'h0100);
    wr(8'h44, 32'h0400);
    wr(OFS_TA, 32'h0300);
    t_pwm(32'h3, 1024);
    t_pwm(32'h1, 4096);
    t_request();
    t_reset();
    report_and_stop();
  end
  initial begin
    repeat (99000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end
endmodule  // tb_top
`default_nettype wire
